// *** pkg/tio_pkg.sv ***
// Constants and types shared by the timed I/O port block.
// Assumes one system clock domain; all port widths start at pin 0.
`default_nettype none

package tio_pkg;

  // ==========================================================
  // Sizes
  localparam int TIO_NPORT  = 3;
  localparam int TIO_NPIN   = 8;
  localparam int TIO_NCB    = 6;
  localparam int TIO_CB_SEL_W = 3;
  localparam int TIO_CB_DIV_W = 8;
  localparam int TIO_CNT_W  = 16;
  localparam int TIO_XFER_W = 32;
  localparam int TIO_SLOT_W = 6;

  // Port widths, narrowest first, and the pins each one covers
  localparam int TIO_PW [TIO_NPORT] = '{1, 4, 8};
  localparam logic [TIO_NPIN-1:0] TIO_PMASK [TIO_NPORT] = '{8'h01, 8'h0F, 8'hFF};
  // Pins taken by the inter-chip link when it is on
  localparam logic [TIO_NPIN-1:0] TIO_LINK_MASK = 8'hF0;

  // ==========================================================
  // Reference clock pacing
  localparam int TIO_SYS_CLK_MHZ = 125;
  localparam int TIO_REF_CLK_MHZ = 100;
  localparam int TIO_ACC_W       = 8;

  // ==========================================================
  // Reset values
  localparam logic [TIO_CB_SEL_W-1:0] TIO_CB_SEL_RST = 3'h0;
  localparam logic [TIO_CNT_W-1:0]    TIO_CNT_RST    = 16'h0000;
  localparam logic [TIO_XFER_W-1:0]   TIO_XFER_RST   = 32'h0000_0000;

  // ==========================================================
  // Port sequencer states
  typedef enum logic [2:0] {
    TIO_ST_IDLE  = 3'b001,
    TIO_ST_WAIT  = 3'b010,
    TIO_ST_SHIFT = 3'b100
  } tio_state_type;

endpackage : tio_pkg

`default_nettype wire

// *** rtl/tio_clkblk.sv ***
// One clock block: picks a tick source and divides it.
// Assumes the external level is already synchronised to clk_sys_i.
`default_nettype none

module tio_clkblk
  import tio_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    nrst_i,
  // Sources
  input  wire logic                    ref_tick_i,
  input  wire logic                    ext_lvl_i,
  // Configuration
  input  wire logic                    src_ext_i,
  input  wire logic [TIO_CB_DIV_W-1:0] div_i,
  // Pacing output
  output logic                         tick_o
);

  logic                    ext_d;
  logic                    src_evt;
  logic [TIO_CB_DIV_W-1:0] div_cnt;

  // ==========================================================
  // Source select
  // Rising edge of the external clock only
  assign src_evt = src_ext_i ? (ext_lvl_i & ~ext_d) : ref_tick_i;

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ext_d <= 1'b0;
    else
      ext_d <= ext_lvl_i;
  end

  // ==========================================================
  // Divider
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      div_cnt <= '0;
      tick_o  <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (src_evt)
      begin
        if (div_cnt >= div_i)
        begin
          div_cnt <= '0;
          tick_o  <= 1'b1;
        end
        else
          div_cnt <= div_cnt + 1'b1;
      end
    end
  end

endmodule // tio_clkblk

`default_nettype wire

// *** rtl/tio_port_top.sv ***
// Timed I/O ports (1, 4 and 8 bits) sharing eight pins, with clock blocks.
// Assumes pins and strobes are asynchronous; config and ops come from clk_sys_i.
//
// What this block does
// - Ports of widths 1, 4, 8 (from the width table) connect to pins.
// - Each port is wholly input or wholly output, never mixed.
// - Ports drive or sample pins; input ports may wait for a pin condition.
// - Input port operations are taken at once; output ones wait for a free transfer register.
// - Data passes through a shift register and a transfer register.
// - Each port has a 16-bit counter timing its transfers.
// - Counter readable always; a transfer may wait for a counter value.
// - Each transfer captures the counter as a timestamp.
// - An enabled link disables the port pins it shares.
// - Narrower enabled port overrules wider ports on shared pins only.
// - A port always transfers at its own width.
// - Port transfer rate is paced by its attached clock block.
// - Six clock blocks; block 0 is the 100 MHz reference.
// - A clock block may take a 1-bit port pin as its source.
// - Input strobe qualifies incoming data; output strobe marks output data.
// - Reset attaches every port to clock block 0; a disabled port then takes port_cb_sel_i.
`default_nettype none

module tio_port_top
  import tio_pkg::*;
#(
  parameter int CB_COUNT = TIO_NCB
)
(
  // Clock and reset
  input  wire logic                                   clk_sys_i,
  input  wire logic                                   nrst_i,
  // Pins
  input  wire logic [TIO_NPIN-1:0]                    pin_i,
  output logic      [TIO_NPIN-1:0]                    pin_o,
  output logic      [TIO_NPIN-1:0]                    pin_oe_o,
  // Link sharing
  input  wire logic                                   link_en_i,
  // Clock block configuration
  input  wire logic [CB_COUNT-1:0]                    cb_src_ext_i,
  input  wire logic [CB_COUNT-1:0][TIO_CB_DIV_W-1:0]  cb_div_i,
  // Port configuration
  input  wire logic [TIO_NPORT-1:0]                   port_en_i,
  input  wire logic [TIO_NPORT-1:0]                   port_out_i,
  input  wire logic [TIO_NPORT-1:0][TIO_CB_SEL_W-1:0] port_cb_sel_i,
  input  wire logic [TIO_NPORT-1:0]                   strobe_en_i,
  input  wire logic [TIO_NPORT-1:0]                   cond_en_i,
  input  wire logic [TIO_NPORT-1:0][TIO_NPIN-1:0]     cond_val_i,
  // Strobes
  input  wire logic [TIO_NPORT-1:0]                   input_strobe_i,
  output logic      [TIO_NPORT-1:0]                   output_strobe_o,
  // Processor operations
  input  wire logic [TIO_NPORT-1:0]                   op_valid_i,
  input  wire logic [TIO_NPORT-1:0][TIO_XFER_W-1:0]   op_data_i,
  input  wire logic [TIO_NPORT-1:0]                   op_timed_i,
  input  wire logic [TIO_NPORT-1:0][TIO_CNT_W-1:0]    op_time_i,
  output logic      [TIO_NPORT-1:0]                   op_ready_o,
  // Read side
  output logic      [TIO_NPORT-1:0]                   rd_valid_o,
  output logic      [TIO_NPORT-1:0][TIO_XFER_W-1:0]   rd_data_o,
  input  wire logic [TIO_NPORT-1:0]                   rd_ack_i,
  // Time
  output logic      [TIO_NPORT-1:0][TIO_CNT_W-1:0]    cnt_o,
  output logic      [TIO_NPORT-1:0][TIO_CNT_W-1:0]    ts_o
);

  // ==========================================================
  // Elaboration checks
  if (CB_COUNT < 2 || CB_COUNT > (1 << TIO_CB_SEL_W))
  begin : g_bad_cb_count
    $error("tio_port_top: CB_COUNT out of range");
  end

  localparam logic [TIO_ACC_W-1:0] REF_STEP = TIO_ACC_W'(TIO_REF_CLK_MHZ);
  localparam logic [TIO_ACC_W-1:0] REF_MOD  = TIO_ACC_W'(TIO_SYS_CLK_MHZ);

  logic [TIO_NPIN-1:0]  pin_m;
  logic [TIO_NPIN-1:0]  pin_s;
  logic [TIO_NPORT-1:0] stb_m;
  logic [TIO_NPORT-1:0] stb_s;
  logic [TIO_ACC_W-1:0] ref_acc;
  logic                 ref_tick;
  logic [CB_COUNT-1:0]  cb_tick;

  logic [TIO_NPORT-1:0]               pt_active;
  logic [TIO_NPORT-1:0][TIO_NPIN-1:0] pt_drive;
  logic [TIO_NPIN-1:0]                next_pin_o;
  logic [TIO_NPIN-1:0]                next_pin_oe;

  // ==========================================================
  // Input synchronisers
  // Pins and strobes come from outside; two flops before any use
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_m <= '0;
      pin_s <= '0;
      stb_m <= '0;
      stb_s <= '0;
    end
    else
    begin
      pin_m <= pin_i;
      pin_s <= pin_m;
      stb_m <= input_strobe_i;
      stb_s <= stb_m;
    end
  end

  // ==========================================================
  // Reference tick
  // 100 of every 125 system cycles; jitter of one cycle traded for no PLL
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ref_acc  <= '0;
      ref_tick <= 1'b0;
    end
    else if (ref_acc + REF_STEP >= REF_MOD)
    begin
      ref_acc  <= ref_acc + REF_STEP - REF_MOD;
      ref_tick <= 1'b1;
    end
    else
    begin
      ref_acc  <= ref_acc + REF_STEP;
      ref_tick <= 1'b0;
    end
  end

  // ==========================================================
  // Clock blocks
  assign cb_tick[0] = ref_tick;

  for (genvar c = 1; c < CB_COUNT; c++)
  begin : g_cb
    tio_clkblk u_cb (
      .clk_sys_i  (clk_sys_i),
      .nrst_i     (nrst_i),
      .ref_tick_i (ref_tick),
      .ext_lvl_i  (pin_s[0]),
      .src_ext_i  (cb_src_ext_i[c]),
      .div_i      (cb_div_i[c]),
      .tick_o     (cb_tick[c])
    );
  end

  // ==========================================================
  // Ports
  for (genvar p = 0; p < TIO_NPORT; p++)
  begin : g_port
    localparam int W = TIO_PW[p];
    localparam logic [TIO_SLOT_W-1:0] LAST = TIO_SLOT_W'(TIO_XFER_W / W - 1);

    tio_state_type           state;
    logic [TIO_CB_SEL_W-1:0] cb_sel;
    logic                    tick;
    logic [TIO_CNT_W-1:0]    cnt;
    logic [TIO_XFER_W-1:0]   shreg;
    logic [TIO_XFER_W-1:0]   xfer;
    logic                    xfer_full;
    logic [TIO_SLOT_W-1:0]   slot;
    logic                    timed;
    logic [TIO_CNT_W-1:0]    when;
    logic                    accept;
    logic                    time_ok;
    logic                    cond_ok;
    logic                    strobe_ok;
    logic [W-1:0]            pins_w;

    assign pins_w    = pin_s[W-1:0];
    assign tick      = (cb_sel < CB_COUNT) ? cb_tick[cb_sel] : cb_tick[0];
    assign time_ok   = !timed || (cnt == when);
    assign cond_ok   = !cond_en_i[p] || (pins_w == cond_val_i[p][W-1:0]);
    assign strobe_ok = !strobe_en_i[p] || stb_s[p];
    // Inputs always take an op; outputs only with the transfer register free
    assign op_ready_o[p] = !port_out_i[p] || !xfer_full;
    assign accept        = op_valid_i[p] && op_ready_o[p];

    // Clock-block attachment, latched when the port is off
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
      if (!nrst_i)
        cb_sel <= TIO_CB_SEL_RST;
      else if (!port_en_i[p])
        cb_sel <= port_cb_sel_i[p];
    end

    // Free-running port counter
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
      if (!nrst_i)
        cnt <= TIO_CNT_RST;
      else if (tick)
        cnt <= cnt + 1'b1;
    end

    // Deferred-time request
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        timed <= 1'b0;
        when  <= TIO_CNT_RST;
      end
      else if (accept)
      begin
        timed <= op_timed_i[p];
        when  <= op_time_i[p];
      end
      // Outputs leave the wait on time alone, so strobe and condition must not hold it
      else if (tick && state == TIO_ST_WAIT && time_ok
               && (port_out_i[p] || (cond_ok && strobe_ok)))
        timed <= 1'b0;
    end

    // Sequencer, shift register and transfer register
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        state     <= TIO_ST_IDLE;
        shreg     <= TIO_XFER_RST;
        xfer      <= TIO_XFER_RST;
        xfer_full <= 1'b0;
        slot      <= '0;
        ts_o[p]   <= TIO_CNT_RST;
      end
      else if (!port_en_i[p])
      begin
        state     <= TIO_ST_IDLE;
        xfer_full <= 1'b0;
        slot      <= '0;
      end
      else if (port_out_i[p])
      begin
        // Output direction
        if (accept)
        begin
          xfer      <= op_data_i[p];
          xfer_full <= 1'b1;
        end
        case (state)
          TIO_ST_IDLE:
            if (xfer_full)
              state <= TIO_ST_WAIT;
          TIO_ST_WAIT:
            if (tick && time_ok)
            begin
              shreg     <= xfer;
              xfer_full <= 1'b0;
              ts_o[p]   <= cnt;
              slot      <= LAST;
              state     <= TIO_ST_SHIFT;
            end
          TIO_ST_SHIFT:
            if (tick)
            begin
              if (slot == '0)
                state <= TIO_ST_IDLE;
              else
              begin
                shreg <= shreg >> W;
                slot  <= slot - 1'b1;
              end
            end
          default:
            state <= TIO_ST_IDLE;
        endcase
      end
      else
      begin
        // Input direction
        if (rd_ack_i[p])
          xfer_full <= 1'b0;
        case (state)
          TIO_ST_IDLE:
            if (!xfer_full)
              state <= TIO_ST_WAIT;
          TIO_ST_WAIT:
            if (tick && time_ok && cond_ok && strobe_ok)
            begin
              shreg <= {pins_w, shreg[TIO_XFER_W-1:W]};
              slot  <= '0;
              state <= (LAST == '0) ? TIO_ST_IDLE : TIO_ST_SHIFT;
              if (LAST == '0)
              begin
                xfer      <= {pins_w, shreg[TIO_XFER_W-1:W]};
                xfer_full <= 1'b1;
                ts_o[p]   <= cnt;
              end
            end
          TIO_ST_SHIFT:
            if (tick && strobe_ok)
            begin
              shreg <= {pins_w, shreg[TIO_XFER_W-1:W]};
              slot  <= slot + 1'b1;
              if (slot + 1'b1 == LAST)
              begin
                // Full word moves to the transfer register
                xfer      <= {pins_w, shreg[TIO_XFER_W-1:W]};
                xfer_full <= 1'b1;
                ts_o[p]   <= cnt;
                state     <= TIO_ST_IDLE;
              end
            end
          default:
            state <= TIO_ST_IDLE;
        endcase
      end
    end

    // Output strobe follows the data shown on the pins
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
      if (!nrst_i)
        output_strobe_o[p] <= 1'b0;
      else
        output_strobe_o[p] <= port_en_i[p] && port_out_i[p]
                              && state == TIO_ST_SHIFT;
    end

    assign pt_active[p] = port_en_i[p] && port_out_i[p] && state == TIO_ST_SHIFT;
    assign pt_drive[p]  = TIO_NPIN'(shreg[W-1:0]);
    assign rd_valid_o[p] = !port_out_i[p] && xfer_full;
    assign rd_data_o[p]  = xfer;
    assign cnt_o[p]      = cnt;
  end

  // ==========================================================
  // Pin ownership and drive
  // Narrowest enabled port wins each pin; link overrides all ports on pins 7..4
  always_comb
  begin
    next_pin_o  = '0;
    next_pin_oe = '0;
    for (int k = 0; k < TIO_NPIN; k++)
    begin
      for (int q = TIO_NPORT - 1; q >= 0; q--)
      begin
        if (port_en_i[q] && TIO_PMASK[q][k])
        begin
          next_pin_o[k]  = pt_drive[q][k];
          next_pin_oe[k] = pt_active[q];
        end
      end
      if (link_en_i && TIO_LINK_MASK[k])
      begin
        next_pin_o[k]  = 1'b0;
        next_pin_oe[k] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_o    <= '0;
      pin_oe_o <= '0;
    end
    else
    begin
      pin_o    <= next_pin_o;
      pin_oe_o <= next_pin_oe;
    end
  end

endmodule // tio_port_top

`default_nettype wire

// *** testbench/tio_port_assertions.sv ***
// Concurrent checks on the timed I/O port block, bound into its top.
// Assumes one clock domain and the bench's fixed port 0 set-up.
`default_nettype none

module tio_port_assertions
  import tio_pkg::*;
(
  // Clock and reset
  input wire logic                                 clk_sys_i,
  input wire logic                                 nrst_i,
  // Pins and configuration
  input wire logic [TIO_NPIN-1:0]                  pin_o,
  input wire logic [TIO_NPIN-1:0]                  pin_oe_o,
  input wire logic                                 link_en_i,
  input wire logic [TIO_NPORT-1:0]                 port_en_i,
  input wire logic [TIO_NPORT-1:0]                 port_out_i,
  input wire logic [TIO_NPORT-1:0][TIO_CB_SEL_W-1:0] port_cb_sel_i,
  // Operations and time
  input wire logic [TIO_NPORT-1:0]                 output_strobe_o,
  input wire logic [TIO_NPORT-1:0]                 op_valid_i,
  input wire logic [TIO_NPORT-1:0]                 op_ready_o,
  input wire logic [TIO_NPORT-1:0]                 rd_valid_o,
  input wire logic [TIO_NPORT-1:0][TIO_XFER_W-1:0] rd_data_o,
  input wire logic [TIO_NPORT-1:0]                 rd_ack_i,
  input wire logic [TIO_NPORT-1:0][TIO_CNT_W-1:0]  cnt_o,
  input wire logic [TIO_NPORT-1:0][TIO_CNT_W-1:0]  ts_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking dflt @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  // ========
  // Pins
  AST_LINK_OFF: assert property (link_en_i && $past(link_en_i) && $past(link_en_i, 2)
    |-> pin_oe_o[7:4] == 4'h0 && pin_o[7:4] == 4'h0) else $error("link pins driven");
  AST_IN_NO_DRIVE: assert property (
    port_out_i == 3'h0 && $past(port_out_i) == 3'h0 && $past(port_out_i, 2) == 3'h0
    |-> pin_oe_o == 8'h00) else $error("input ports drive pins");
  // Pin 0 belongs to the enabled 1-bit input port
  AST_STROBE_PINS: assert property (
    output_strobe_o[1] && $past(port_en_i[0] && !port_out_i[0])
    |-> pin_oe_o[3:0] == 4'hE) else $error("4-bit port pins wrong");

  // ========
  // Operations
  AST_IN_READY: assert property (!port_out_i[0] |-> op_ready_o[0])
    else $error("input port not ready");
  AST_OUT_TAKE: assert property (
    op_valid_i[1] && op_ready_o[1] && port_out_i[1] && port_en_i[1] |=> !op_ready_o[1])
    else $error("transfer register not taken");
  AST_RD_HOLD: assert property (rd_valid_o[1] && !rd_ack_i[1] && port_en_i[1]
    |=> rd_valid_o[1] && $stable(rd_data_o[1]) && $stable(ts_o[1]))
    else $error("input word lost");

  // ========
  // Time
  AST_CNT_STEP: assert property ($changed(cnt_o[0])
    |-> cnt_o[0] == $past(cnt_o[0]) + 16'h0001) else $error("counter step wrong");
  // Reference ticks miss one cycle in five, never several in a row
  AST_REF_RATE: assert property (port_en_i[0] && port_cb_sel_i[0] == 3'h0
    |-> ##[0:4] $changed(cnt_o[0])) else $error("reference counter stalled");

  cover property (output_strobe_o[1]);
  cover property ($rose(rd_valid_o[1]));
  cover property (link_en_i && output_strobe_o[2]);
endmodule // tio_port_assertions

bind tio_port_top tio_port_assertions tio_port_assertions_i (.*);

`default_nettype wire

// *** testbench/tio_pins_model.sv ***
// Far-side hardware on the eight pins: data source, strobe, clock.
// Assumes the design's pin outputs; undriven pins fall to the pull-down.
`default_nettype none

module tio_pins_model
  import tio_pkg::*;
(
  // From the design
  input  wire logic [TIO_NPIN-1:0]  pin_val_i,
  input  wire logic [TIO_NPIN-1:0]  pin_drv_i,
  // From the bench
  input  wire logic                 ext_run_i,
  input  wire logic                 drv_en_i,
  input  wire logic [TIO_NPIN-1:0]  drv_val_i,
  input  wire logic                 stb_i,
  // To the design
  output logic      [TIO_NPIN-1:0]  lvl_o,
  output logic      [TIO_NPORT-1:0] stb_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic ext_clk = 1'b0;

  // ========
  // Application clock, 160 ns, still between frames
  initial
  begin
    #3;
    forever #80 ext_clk = ext_run_i && !ext_clk;
  end

  // ========
  // Pin levels: the design's drive wins
  always_comb
  begin
    lvl_o = drv_en_i ? drv_val_i : 8'h00;
    lvl_o[0] = ext_clk;
    for (int i = 0; i < TIO_NPIN; i++)
      if (pin_drv_i[i])
        lvl_o[i] = pin_val_i[i];
  end

  assign stb_o = {TIO_NPORT{stb_i}};
endmodule // tio_pins_model

`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the timed I/O ports and clock blocks.
// Assumes the pin model on the far side and the bound checker.
`default_nettype none

module tb
  import tio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                                 clk_sys_i = 1'b0;
  logic                                 nrst_i = 1'b0;
  logic                                 link_en_i = 1'b0;
  logic [TIO_NPIN-1:0]                  pin_i, pin_o, pin_oe_o;
  logic [TIO_NCB-1:0]                   cb_src_ext_i = 6'h04;
  logic [TIO_NCB-1:0][TIO_CB_DIV_W-1:0] cb_div_i = 48'h0000_0000_0300;
  logic [TIO_NPORT-1:0]                 port_en_i = 3'h1, port_out_i = 3'h0;
  logic [TIO_NPORT-1:0]                 strobe_en_i = 3'h2, cond_en_i = 3'h0;
  logic [TIO_NPORT-1:0]                 op_valid_i = 3'h0, op_timed_i = 3'h0;
  logic [TIO_NPORT-1:0]                 rd_ack_i = 3'h0, input_strobe_i;
  logic [TIO_NPORT-1:0]                 output_strobe_o, op_ready_o, rd_valid_o;
  logic [TIO_NPORT-1:0][TIO_CB_SEL_W-1:0] port_cb_sel_i = 9'h008;
  logic [TIO_NPORT-1:0][TIO_NPIN-1:0]   cond_val_i = 24'h000000;
  logic [TIO_NPORT-1:0][TIO_XFER_W-1:0] op_data_i = 96'h0, rd_data_o;
  logic [TIO_NPORT-1:0][TIO_CNT_W-1:0]  op_time_i = 48'h0, cnt_o, ts_o;
  logic                                 ext_run = 1'b0, drv_en = 1'b0, stb = 1'b0;
  logic [TIO_NPIN-1:0]                  drv_val = 8'h0A;
  logic [2:0]                           seen [$];
  logic [2:0]                           last_nib;
  logic [31:0]                          d;
  logic [15:0]                          t0;
  int                                   miscompares = 0, comparisons = 0;

  always #4 clk_sys_i = !clk_sys_i;

  tio_port_top #(.CB_COUNT(TIO_NCB)) tio_port_top_i (.*);

  tio_pins_model tio_pins_model_i (
    .pin_val_i (pin_o),
    .pin_drv_i (pin_oe_o),
    .ext_run_i (ext_run),
    .drv_en_i  (drv_en),
    .drv_val_i (drv_val),
    .stb_i     (stb),
    .lvl_o     (pin_i),
    .stb_o     (input_strobe_i)
  );

  // ========
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds valid up so back-to-back calls need no gap
  task automatic wr(input int p, input logic [31:0] v, input logic tm, input logic [15:0] at);
    int n;
    op_valid_i[p] <= 1'b1;
    op_data_i[p] <= v;
    op_timed_i[p] <= tm;
    op_time_i[p] <= at;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end while (op_ready_o[p] !== 1'b1 && n < 500);
    if (op_ready_o[p] !== 1'b1)
      miscompares++;
  endtask

  task automatic rd(input int p, output logic [31:0] v);
    for (int n = 0; n < 2000 && rd_valid_o[p] !== 1'b1; n++)
      @(posedge clk_sys_i);
    if (rd_valid_o[p] !== 1'b1)
      miscompares++;
    v = rd_data_o[p];
    rd_ack_i[p] <= 1'b1;
    @(posedge clk_sys_i);
    rd_ack_i[p] <= 1'b0;
  endtask

  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Pin 0 is overruled, so only pins 3..1 of each nibble are logged
  always @(posedge clk_sys_i)
    if (output_strobe_o[1] === 1'b1 && pin_o[3:1] !== last_nib)
    begin
      seen.push_back(pin_o[3:1]);
      last_nib = pin_o[3:1];
    end

  // ========
  // Tests
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    check(pin_oe_o, 8'h00);
    check(op_ready_o, 3'h7);
    nrst_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    t0 = cnt_o[0];
    repeat (125) @(posedge clk_sys_i);
    check(16'(cnt_o[0] - t0), 16'h0064);
    $display("test clock done");

    port_out_i <= 3'h2;
    @(posedge clk_sys_i);
    port_en_i <= 3'h3;
    @(posedge clk_sys_i);
    t0 = cnt_o[1] + 16'h0014;
    wr(1, 32'h0ECA_8642, 1'b1, t0);
    wr(1, 32'h0ECA_8642, 1'b0, 16'h0000);
    op_valid_i <= 3'h0;
    check(ts_o[1], t0);
    repeat (150) @(posedge clk_sys_i);
    check(seen.size(), 16);
    for (int i = 0; i < 16; i++)
      check(seen[i], (i + 1) % 8);
    $display("test output done");

    port_en_i <= 3'h1;
    @(posedge clk_sys_i);
    port_out_i <= 3'h4;
    link_en_i <= 1'b1;
    port_cb_sel_i[1] <= 3'h2;
    @(posedge clk_sys_i);
    port_en_i <= 3'h5;
    @(posedge clk_sys_i);
    wr(2, 32'hA5C3_0FF0, 1'b0, 16'h0000);
    op_valid_i <= 3'h0;
    for (int n = 0; n < 100 && output_strobe_o[2] !== 1'b1; n++)
      @(posedge clk_sys_i);
    check(pin_oe_o, 8'h0E);
    check(pin_o[3:1], 3'h0);
    repeat (60) @(posedge clk_sys_i);
    port_en_i <= 3'h1;
    link_en_i <= 1'b0;
    @(posedge clk_sys_i);
    port_out_i <= 3'h0;
    $display("test link done");

    drv_en <= 1'b1;
    stb <= 1'b1;
    ext_run <= 1'b1;
    @(posedge clk_sys_i);
    port_en_i <= 3'h3;
    rd(1, d);
    check(d & 32'hEEEE_EEEE, 32'hAAAA_AAAA);
    stb <= 1'b0;
    repeat (200) @(posedge clk_sys_i);
    check(rd_valid_o[1], 1'b0);
    // Pins never show 5, so the first sample must wait
    cond_en_i[1] <= 1'b1;
    cond_val_i[1] <= 8'h05;
    stb <= 1'b1;
    repeat (200) @(posedge clk_sys_i);
    check(rd_valid_o[1], 1'b0);
    cond_val_i[1] <= 8'h0B;
    rd(1, d);
    check(d & 32'hEEEE_EEEE, 32'hAAAA_AAAA);
    ext_run <= 1'b0;
    $display("test input done");
    summarize();
  end

  // Run needs near 1200 cycles; this allows about ten times that
  initial
  begin
    #100000;
    miscompares++;
    summarize();
  end
endmodule // tb

`default_nettype wire
